/* scan_defs.svh */
// register map, field positions, reset values and timing counts
`ifndef SCAN_DEFS_SVH
`define SCAN_DEFS_SVH

`define REG_CTRL 8'h00
`define REG_PACER 8'h04
`define REG_QLEN 8'h08
`define REG_STAT 8'h0C
`define REG_SWDATA 8'h10
`define REG_QBASE 2'h1

`define CTRL_HW 0
`define CTRL_START 1
`define CTRL_STOP 2
`define CTRL_BURST 3
`define CTRL_EXTCLK 4
`define CTRL_TRIGEN 5
`define CTRL_TRIGLO 6
`define CTRL_SWCONV 8

`define STAT_RUN 0
`define STAT_ARMED 1
`define STAT_OVR 2
`define STAT_SWBUSY 3
`define STAT_SWVALID 4
`define STAT_LVLLO 8

`define EXT_START_EVENT_PIN_RISE 2'h0
`define EXT_START_EVENT_PIN_FALL 2'h1
`define EXT_START_EVENT_PIN_HIGH 2'h2
`define EXT_START_EVENT_PIN_LOW 2'h3

`define PACER_RST 32'h0000_0190
`define SYS_CLK_MHZ 200
`define BURST_NS 2000
`define BURST_CYC ((`BURST_NS * `SYS_CLK_MHZ + 999) / 1000)
`define MAX_AGG_KSPS 500
`define MIN_SAMPLE_CYC \
  ((`SYS_CLK_MHZ * 1000 + `MAX_AGG_KSPS - 1) / `MAX_AGG_KSPS)
`define BLINK_MS 50
`define BLINK_CYC_DEF (`BLINK_MS * `SYS_CLK_MHZ * 1000)

`endif

/* scan_pkg.sv */
// shared types of the scan pacing block
`default_nettype none
package scan_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARMED = 3'b001,
    ST_WAIT = 3'b010,
    ST_CONV = 3'b011,
    ST_GAP = 3'b100,
    ST_SWCONV = 3'b101
  } seq_state_t;

  // one channel-gain list element
  typedef struct packed {
    logic [1:0] range;
    logic diff;
    logic [3:0] chan;
  } cg_entry_t;

  typedef struct packed {
    logic [7:0] paddr;
    logic pwrite;
    logic [31:0] pwdata;
    logic psel;
    logic penable;
  } apb_req_t;

  typedef struct packed {
    logic done;
    logic [15:0] data;
  } adc_res_t;

  typedef struct packed {
    logic [1:0] trigMode;
    logic trigEn;
    logic extClk;
    logic burst;
    logic hw;
  } ctrl_t;
endpackage
`default_nettype wire

/* scan_fifo.sv */
// sample fifo between the sequencer and the host drain port
`timescale 1ns/100ps
`default_nettype none
module scan_fifo #(
  parameter int W = 16,
  parameter int D = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData,
  output logic [$clog2(D+1)-1:0] level
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D+1);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] rp;
    logic [AW-1:0] wp;
    logic [CW-1:0] cnt;
  } fifo_state_t;
  fifo_state_t s, next_s;
  logic push, pop;

  // handshakes straight from the occupancy count
  assign inReady = s.cnt != CW'(D);
  assign outValid = s.cnt != '0;
  assign outData = s.mem[s.rp];
  assign level = s.cnt;
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  // pointer and count update
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp] = inData;
      next_s.wp = s.wp + 1'b1;
    end
    if (pop) begin
      next_s.rp = s.rp + 1'b1;
    end
    if (push && !pop) begin
      next_s.cnt = s.cnt + 1'b1;
    end else if (pop && !push) begin
      next_s.cnt = s.cnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

/* scan_cgmem.sv */
// channel-gain list memory, one write port and two registered read ports
`timescale 1ns/100ps
`default_nettype none
module scan_cgmem #(
  parameter int N = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wrEn,
  input wire logic [$clog2(N)-1:0] wrAddr,
  input wire scan_pkg::cg_entry_t wrData,
  input wire logic [$clog2(N)-1:0] rdAddrA,
  output scan_pkg::cg_entry_t rdDataA,
  input wire logic [$clog2(N)-1:0] rdAddrB,
  output scan_pkg::cg_entry_t rdDataB
);
  import scan_pkg::*;
  typedef struct packed {
    cg_entry_t [N-1:0] mem;
    cg_entry_t rdA;
    cg_entry_t rdB;
  } mem_state_t;
  mem_state_t s, next_s;

  assign rdDataA = s.rdA;
  assign rdDataB = s.rdB;

  // write and both reads land on the same edge
  always_comb begin
    next_s = s;
    next_s.rdA = s.mem[rdAddrA];
    next_s.rdB = s.mem[rdAddrB];
    if (wrEn) begin
      next_s.mem[wrAddr] = wrData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

/* scan_pacing_ctrl.sv */
// analog scan pacing control: apb registers, pacer, sequencer, leds
//
// Function
// - software mode: one conversion per command, result held until read
// - hardware mode scans list continuously into the fifo until stopped
// - fifo drains to host in blocks; host must keep draining
// - scan starts on start command or on external trigger when enabled
// - internal pacer period clamped so aggregate rate stays within 500 kS/s
// - burst: one pacer tick samples all list channels back to back
// - burst: channel samples inside a scan spaced exactly 2 us
// - no burst: every sample waits for its own pacer tick
// - pacer source selectable internal or external clock input
// - external pacer clock forces burst timing
// - activity led blinks during host transfers, off otherwise
// - status led on once host has configured the device
// - after lost link status led stays off until reconnection
// - pacer clock out repeats external clock, else internal scan clock
// - scan follows a list of up to 16 channel, mode, range entries
// - trigger edge or level, either polarity, rising edge after reset
`timescale 1ns/100ps
`default_nettype none
`include "scan_defs.svh"
module scan_pacing_ctrl #(
  parameter int FIFO_W = 16,
  parameter int FIFO_D = 4,
  parameter int BLOCK_WORDS = 2,
  parameter int BLINK_CYC = `BLINK_CYC_DEF
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire scan_pkg::apb_req_t apbReq,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic adcStart,
  output scan_pkg::cg_entry_t adcCfg,
  input wire scan_pkg::adc_res_t adcResult,
  output logic xferValid,
  input wire logic xferReady,
  output logic [FIFO_W-1:0] xferData,
  output logic xferBlock,
  input wire logic ext_pacer_clock_in,
  input wire logic ext_start_event_pin,
  output logic pacer_clock_out,
  input wire logic usbAttached,
  input wire logic usbConfigured,
  output logic statusLed,
  output logic actLed
);
  import scan_pkg::*;
  localparam int LW = $clog2(FIFO_D+1);
  localparam logic [31:0] ACT_CYC = 32'(2 * BLINK_CYC);

  typedef struct packed {
    seq_state_t st;
    logic issued;
    logic [3:0] idx;
    ctrl_t ctrl;
    logic [31:0] period;
    logic [3:0] qlen;
    logic overrun;
    logic swValid;
    logic [15:0] swData;
    logic adcStart;
    cg_entry_t cfg;
    logic [31:0] pcnt;
    logic [15:0] gcnt;
    logic [2:0] trgSync;
    logic trgStable;
    logic [2:0] clkSync;
    logic clkStable;
    logic pacerOut;
    logic [31:0] rdata;
    logic slvErr;
    logic qWait;
    logic [31:0] actWin;
    logic [31:0] blinkCnt;
    logic actLed;
    logic lost;
    logic statusLed;
  } ctrl_state_t;
  ctrl_state_t s, next_s;

  logic setup, access, done, wrDone, startW, stopW, swConvW;
  logic burstEff, running, intTick, tick, clkRise, trigFire, xferFire;
  logic fifoReady, fifoPush;
  logic [LW-1:0] fifoLevel;
  logic [31:0] minPer, effPer;
  cg_entry_t memRdA, memRdB;

  // queue entries sit in the 0x40..0x7C window
  function automatic logic isQueue(input logic [7:0] a);
    return a[7:6] == `REG_QBASE;
  endfunction

  function automatic logic isMapped(input logic [7:0] a);
    return isQueue(a) || a == `REG_CTRL || a == `REG_PACER ||
      a == `REG_QLEN || a == `REG_STAT || a == `REG_SWDATA;
  endfunction

  // stable-level change seen once second and third stages agree
  function automatic logic filtEdge(input logic [2:0] sy, input logic st,
                                    input logic want);
    return (sy[1] == sy[2]) && (sy[2] != st) && (sy[2] == want);
  endfunction

  // apb phase decode; queue reads take one wait state
  assign setup = apbReq.psel & ~apbReq.penable;
  assign access = apbReq.psel & apbReq.penable;
  assign pready = ~(access & isQueue(apbReq.paddr) & ~apbReq.pwrite &
    ~s.qWait);
  assign done = access & pready;
  assign wrDone = done & apbReq.pwrite & isMapped(apbReq.paddr);
  assign startW = wrDone & (apbReq.paddr == `REG_CTRL) &
    apbReq.pwdata[`CTRL_START];
  assign stopW = wrDone & (apbReq.paddr == `REG_CTRL) &
    apbReq.pwdata[`CTRL_STOP];
  assign swConvW = wrDone & (apbReq.paddr == `REG_CTRL) &
    apbReq.pwdata[`CTRL_SWCONV];
  assign prdata = s.rdata;
  assign pslverr = s.slvErr;

  // pacer: period clamp and tick source
  assign burstEff = s.ctrl.burst | s.ctrl.extClk;
  assign minPer = burstEff ? ({28'h0, s.qlen} + 32'h1) * 32'(`BURST_CYC)
    : 32'(`MIN_SAMPLE_CYC);
  assign effPer = (s.period < minPer) ? minPer : s.period;
  assign running = s.st == ST_WAIT || s.st == ST_CONV || s.st == ST_GAP;
  assign intTick = running & ~s.ctrl.extClk & (s.pcnt >= effPer - 32'h1);
  assign clkRise = filtEdge(s.clkSync, s.clkStable, 1'b1);
  assign tick = s.ctrl.extClk ? (running & clkRise) : intTick;

  // start trigger qualification
  always_comb begin
    unique case (s.ctrl.trigMode)
      `EXT_START_EVENT_PIN_RISE: trigFire = filtEdge(s.trgSync, s.trgStable, 1'b1);
      `EXT_START_EVENT_PIN_FALL: trigFire = filtEdge(s.trgSync, s.trgStable, 1'b0);
      `EXT_START_EVENT_PIN_HIGH: trigFire = s.trgStable;
      `EXT_START_EVENT_PIN_LOW: trigFire = ~s.trgStable;
    endcase
  end

  // sample path into the fifo and host drain side
  assign fifoPush = s.st == ST_CONV && s.issued && adcResult.done;
  assign xferFire = xferValid & xferReady;
  assign xferBlock = (fifoLevel >= LW'(BLOCK_WORDS)) ||
    (xferValid && !running);
  assign adcStart = s.adcStart;
  assign adcCfg = s.cfg;
  assign pacer_clock_out = s.pacerOut;
  assign statusLed = s.statusLed;
  assign actLed = s.actLed;

  scan_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .inValid(fifoPush),
    .inReady(fifoReady),
    .inData(adcResult.data),
    .outValid(xferValid),
    .outReady(xferReady),
    .outData(xferData),
    .level(fifoLevel)
  );

  scan_cgmem #(.N(16)) u_cgmem (
    .sys_clk(sys_clk),
    .rst(rst),
    .wrEn(wrDone & isQueue(apbReq.paddr)),
    .wrAddr(apbReq.paddr[5:2]),
    .wrData(apbReq.pwdata[6:0]),
    .rdAddrA(apbReq.paddr[5:2]),
    .rdDataA(memRdA),
    .rdAddrB(next_s.idx),
    .rdDataB(memRdB)
  );

  // whole next state of the block
  always_comb begin
    next_s = s;
    next_s.adcStart = 1'b0;
    // pin synchronisers and filtered levels
    next_s.trgSync = {s.trgSync[1:0], ext_start_event_pin};
    next_s.clkSync = {s.clkSync[1:0], ext_pacer_clock_in};
    if (s.trgSync[1] == s.trgSync[2]) next_s.trgStable = s.trgSync[2];
    if (s.clkSync[1] == s.clkSync[2]) next_s.clkStable = s.clkSync[2];
    next_s.pacerOut = s.ctrl.extClk ? s.clkStable : intTick;
    next_s.pcnt = (!running || intTick) ? 32'h0 : s.pcnt + 32'h1;
    next_s.gcnt = s.gcnt + 16'h1;
    // apb read capture and register writes
    if (setup) begin
      next_s.slvErr = !isMapped(apbReq.paddr);
      next_s.rdata = 32'h0;
      unique case (apbReq.paddr)
        `REG_CTRL: begin
          next_s.rdata[`CTRL_HW] = s.ctrl.hw;
          next_s.rdata[`CTRL_BURST] = s.ctrl.burst;
          next_s.rdata[`CTRL_EXTCLK] = s.ctrl.extClk;
          next_s.rdata[`CTRL_TRIGEN] = s.ctrl.trigEn;
          next_s.rdata[`CTRL_TRIGLO +: 2] = s.ctrl.trigMode;
        end
        `REG_PACER: next_s.rdata = s.period;
        `REG_QLEN: next_s.rdata[3:0] = s.qlen;
        `REG_STAT: begin
          next_s.rdata[`STAT_RUN] = running;
          next_s.rdata[`STAT_ARMED] = s.st == ST_ARMED;
          next_s.rdata[`STAT_OVR] = s.overrun;
          next_s.rdata[`STAT_SWBUSY] = s.st == ST_SWCONV;
          next_s.rdata[`STAT_SWVALID] = s.swValid;
          next_s.rdata[`STAT_LVLLO +: LW] = fifoLevel;
        end
        `REG_SWDATA: next_s.rdata[15:0] = s.swData;
        default: next_s.rdata = 32'h0;
      endcase
    end
    if (access && isQueue(apbReq.paddr) && !apbReq.pwrite && !s.qWait) begin
      next_s.qWait = 1'b1;
      next_s.rdata = {25'h0, memRdA};
    end
    if (done) next_s.qWait = 1'b0;
    if (wrDone && apbReq.paddr == `REG_CTRL) begin
      next_s.ctrl.hw = apbReq.pwdata[`CTRL_HW];
      next_s.ctrl.burst = apbReq.pwdata[`CTRL_BURST];
      next_s.ctrl.extClk = apbReq.pwdata[`CTRL_EXTCLK];
      next_s.ctrl.trigEn = apbReq.pwdata[`CTRL_TRIGEN];
      next_s.ctrl.trigMode = apbReq.pwdata[`CTRL_TRIGLO +: 2];
    end
    if (wrDone && apbReq.paddr == `REG_PACER) next_s.period = apbReq.pwdata;
    if (wrDone && apbReq.paddr == `REG_QLEN) begin
      next_s.qlen = apbReq.pwdata[3:0];
    end
    if (wrDone && apbReq.paddr == `REG_STAT && apbReq.pwdata[`STAT_OVR]) begin
      next_s.overrun = 1'b0;
    end
    if (done && !apbReq.pwrite && apbReq.paddr == `REG_SWDATA) begin
      next_s.swValid = 1'b0;
    end
    // sequencer
    unique case (s.st)
      ST_IDLE: begin
        next_s.idx = 4'h0;
        if (startW && next_s.ctrl.hw) begin
          next_s.st = next_s.ctrl.trigEn ? ST_ARMED : ST_WAIT;
        end else if (swConvW && !next_s.ctrl.hw) begin
          next_s.st = ST_SWCONV;
          next_s.issued = 1'b0;
        end
      end
      ST_ARMED: begin
        if (trigFire) next_s.st = ST_WAIT;
      end
      ST_WAIT: begin
        if (tick) begin
          next_s.st = ST_CONV;
          next_s.issued = 1'b0;
        end
      end
      ST_CONV, ST_SWCONV: begin
        if (!s.issued) begin
          next_s.adcStart = 1'b1;
          next_s.cfg = memRdB;
          next_s.issued = 1'b1;
          next_s.gcnt = 16'h0;
        end else if (adcResult.done) begin
          if (s.st == ST_SWCONV) begin
            next_s.swData = adcResult.data;
            next_s.swValid = 1'b1;
            next_s.st = ST_IDLE;
          end else if (!fifoReady) begin
            next_s.overrun = 1'b1;
            next_s.st = ST_IDLE;
          end else if (s.idx == s.qlen) begin
            next_s.idx = 4'h0;
            next_s.st = ST_WAIT;
          end else begin
            next_s.idx = s.idx + 4'h1;
            next_s.st = burstEff ? ST_GAP : ST_WAIT;
          end
        end
      end
      ST_GAP: begin
        if (s.gcnt >= 16'(`BURST_CYC - 2)) begin
          next_s.st = ST_CONV;
          next_s.issued = 1'b0;
        end
      end
      default: next_s.st = ST_IDLE;
    endcase
    if (stopW && s.st != ST_SWCONV) next_s.st = ST_IDLE;
    // activity window and blink
    if (xferFire) next_s.actWin = ACT_CYC;
    else if (s.actWin != 32'h0) next_s.actWin = s.actWin - 32'h1;
    if (next_s.actWin == 32'h0) begin
      next_s.actLed = 1'b0;
      next_s.blinkCnt = 32'h0;
    end else if (s.actWin == 32'h0) begin
      next_s.actLed = 1'b1;
    end else if (s.blinkCnt >= 32'(BLINK_CYC) - 32'h1) begin
      next_s.actLed = ~s.actLed;
      next_s.blinkCnt = 32'h0;
    end else begin
      next_s.blinkCnt = s.blinkCnt + 32'h1;
    end
    // status led follows configuration, latched off on a lost link
    if (!usbAttached) next_s.lost = 1'b0;
    else if (s.statusLed && !usbConfigured) next_s.lost = 1'b1;
    next_s.statusLed = usbAttached & usbConfigured & ~next_s.lost;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;
      s.period <= `PACER_RST;
    end else begin
      s <= next_s;
    end
  end

  // helpers for the checks below
  logic viaGap;
  logic [15:0] sinceStart;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      viaGap <= 1'b0;
      sinceStart <= 16'h0;
    end else begin
      if (s.st == ST_GAP && next_s.st == ST_CONV) viaGap <= 1'b1;
      else if (s.adcStart) viaGap <= 1'b0;
      sinceStart <= s.adcStart ? 16'h1 : sinceStart + 16'h1;
    end
  end

  default clocking dcb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_convDone;
    s.st == ST_CONV && s.issued && adcResult.done && !stopW;
  endsequence
  sequence s_swDone;
    s.st == ST_SWCONV && s.issued && adcResult.done;
  endsequence

  property p_swResult;
    s_swDone |=> s.swValid && s.st == ST_IDLE &&
      s.swData == $past(adcResult.data);
  endproperty
  a_swResult: assert property (p_swResult)
    else $error("software result not captured");

  property p_push;
    s_convDone ##0 (fifoReady && !xferFire) |=>
      fifoLevel == $past(fifoLevel) + LW'(1);
  endproperty
  a_push: assert property (p_push)
    else $error("sample not written to fifo");

  property p_overrun;
    s_convDone ##0 !fifoReady |=> s.overrun && s.st == ST_IDLE;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("full fifo did not stop scan");

  property p_burstGap;
    s.adcStart && viaGap |-> sinceStart == 16'(`BURST_CYC);
  endproperty
  a_burstGap: assert property (p_burstGap)
    else $error("burst sample spacing wrong");

  property p_extBurst;
    s_convDone ##0 (fifoReady && s.ctrl.extClk && s.idx != s.qlen) |=>
      s.st == ST_GAP ##[1:400] (s.st == ST_CONV || stopW);
  endproperty
  a_extBurst: assert property (p_extBurst)
    else $error("external clock scan not in burst");

  property p_noBurst;
    s_convDone ##0 (fifoReady && !burstEff) |=> s.st == ST_WAIT;
  endproperty
  a_noBurst: assert property (p_noBurst)
    else $error("non burst sample did not wait for tick");

  property p_waitTick;
    s.st == ST_WAIT && !tick && !stopW |=> s.st == ST_WAIT;
  endproperty
  a_waitTick: assert property (p_waitTick)
    else $error("scan began without pacer tick");

  property p_trigStart;
    s.st == ST_ARMED && trigFire && !stopW |=> s.st == ST_WAIT;
  endproperty
  a_trigStart: assert property (p_trigStart)
    else $error("trigger did not start scan");

  property p_clkOut;
    s.ctrl.extClk |=> pacer_clock_out == $past(s.clkStable);
  endproperty
  a_clkOut: assert property (p_clkOut)
    else $error("pacer out not following external clock");

  property p_lostLink;
    $fell(statusLed) && $past(usbAttached) |-> s.lost ##1 !statusLed;
  endproperty
  a_lostLink: assert property (p_lostLink)
    else $error("status led lost state not held");

  property p_statusOn;
    statusLed |-> $past(usbConfigured) && $past(usbAttached);
  endproperty
  a_statusOn: assert property (p_statusOn)
    else $error("status led on without configuration");

  property p_actOff;
    actLed |-> s.actWin != 32'h0;
  endproperty
  a_actOff: assert property (p_actOff)
    else $error("activity led on with no transfer");
endmodule
`default_nettype wire

/* scan_host_model.sv */
// far side model: converter answering starts and host draining the fifo
`timescale 1ns/100ps
`default_nettype none
module scan_host_model #(
  parameter int LAT = 20
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic adcStart,
  input wire scan_pkg::cg_entry_t adcCfg,
  output scan_pkg::adc_res_t adcResult,
  input wire logic drainEn,
  output logic xferReady
);
  import scan_pkg::*;
  int cnt;
  cg_entry_t cfgR;
  // one answer per start after a fixed latency; data churns when idle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt <= 0;
      cfgR <= '0;
      adcResult <= '0;
      xferReady <= 1'b0;
    end else begin
      cnt <= adcStart ? LAT : (cnt > 0 ? cnt - 1 : 0);
      if (adcStart) begin
        cfgR <= adcCfg;
      end
      adcResult.done <= (cnt == 1);
      adcResult.data <= (cnt == 1) ? {9'h155, cfgR} : ~adcResult.data;
      xferReady <= drainEn;
    end
  end
endmodule
`default_nettype wire

/* analog_scan_pacing_control_tb.sv */
// self-checking bench of the scan pacing block
`timescale 1ns/100ps
`default_nettype none
`include "scan_defs.svh"
`define CHK(a, e) begin totalChecks++; if ((a) !== (e)) begin nErrors++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module analog_scan_pacing_control_tb;
  import scan_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  apb_req_t apbReq = '0;
  logic [31:0] prdata;
  logic pready, pslverr, adcStart, xferValid, xferReady, xferBlock;
  cg_entry_t adcCfg;
  adc_res_t adcResult;
  logic [15:0] xferData;
  logic extPacer = 1'b0;
  logic extStart = 1'b0;
  logic usbAtt = 1'b0;
  logic usbCfg = 1'b0;
  logic drainEn = 1'b1;
  logic pacerOut, statusLed, actLed;
  logic actSeen = 1'b0;
  int nErrors = 0;
  int totalChecks = 0;
  int cyc = 0;
  int starts[$];
  int pulses[$];
  logic [15:0] got[$];
  logic [31:0] rd;
  logic err;
  cg_entry_t ent [4] = '{7'h05, 7'h31, 7'h4F, 7'h05};
  logic [1:0] stTab [6] = '{2'h2, 2'h3, 2'h2, 2'h3, 2'h0, 2'h3};
  logic [5:0] ledExp = 6'h22;

  scan_pacing_ctrl #(.BLINK_CYC(8)) DUT (.sys_clk(sys_clk), .rst(rst),
    .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adcStart(adcStart), .adcCfg(adcCfg), .adcResult(adcResult),
    .xferValid(xferValid), .xferReady(xferReady), .xferData(xferData),
    .xferBlock(xferBlock), .ext_pacer_clock_in(extPacer),
    .ext_start_event_pin(extStart), .pacer_clock_out(pacerOut),
    .usbAttached(usbAtt), .usbConfigured(usbCfg),
    .statusLed(statusLed), .actLed(actLed));
  scan_host_model host (.sys_clk(sys_clk), .rst(rst), .adcStart(adcStart),
    .adcCfg(adcCfg), .adcResult(adcResult), .drainEn(drainEn),
    .xferReady(xferReady));

  // 200 MHz clock
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  // cycle count, start times, drained words and the hang limit
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (adcStart) starts.push_back(cyc);
    if (pacerOut) pulses.push_back(cyc);
    if (xferValid && xferReady) got.push_back(xferData);
    if (actLed) actSeen <= 1'b1;
    if (cyc > 60000) begin
      nErrors++;
      testDone();
    end
  end

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    apbReq <= '{paddr: a, pwrite: w, pwdata: d, psel: 1'b1, penable: 1'b0};
    @(posedge sys_clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apbReq <= '0;
    @(posedge sys_clk);
  endtask

  task automatic waitStat(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(0, `REG_STAT, 0);
      n++;
    end while (rd[b] !== v && n < 3000);
  endtask

  // run a scan, stop it, then check sample spacing and list order
  task automatic runScan(input logic [31:0] ctl, input int per,
      input int sp, input int scan);
    apb(1, `REG_PACER, per);
    starts.delete();
    pulses.delete();
    got.delete();
    apb(1, `REG_CTRL, ctl);
    for (int n = 0; n < 9000 && starts.size() < 5; n++) @(posedge sys_clk);
    apb(1, `REG_CTRL, 32'h5);
    repeat (60) @(posedge sys_clk);
    `CHK(starts[2] - starts[1], sp)
    `CHK(starts[4] - starts[0], scan)
    `CHK(starts[0] - pulses[0], 1)
    for (int i = 0; i < 4; i++) `CHK(got[i], {9'h155, ent[i]})
  endtask

  task automatic testDone();
    $display("checks %0d errors %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    apb(0, `REG_PACER, 0); `CHK(rd, `PACER_RST)
    apb(0, `REG_CTRL, 0); `CHK(rd[7:0], 8'h00)
    apb(0, 8'h20, 0); `CHK({err, rd}, 33'h1_0000_0000)
    apb(1, `REG_QLEN, 3);
    for (int i = 0; i < 4; i++) apb(1, 8'h40 + 8'(4 * i), 32'(ent[i]));
    for (int i = 0; i < 4; i++) begin
      apb(0, 8'h40 + 8'(4 * i), 0); `CHK(rd[6:0], ent[i])
    end
    // software conversion
    starts.delete();
    apb(1, `REG_CTRL, 32'h100);
    waitStat(`STAT_SWVALID, 1'b1);
    `CHK(starts.size(), 1)
    apb(0, `REG_SWDATA, 0); `CHK(rd[15:7], 9'h155)
    apb(0, `REG_STAT, 0); `CHK(rd[`STAT_SWVALID], 1'b0)
    // burst, even spacing, and both with a too short pacer period
    runScan(32'h0B, 2000, 400, 2000);
    runScan(32'h03, 500, 500, 2000);
    runScan(32'h0B, 100, 400, 1600);
    runScan(32'h03, 100, 400, 1600);
    // external pacer clock forces burst and is echoed out
    starts.delete();
    apb(1, `REG_CTRL, 32'h13);
    extPacer <= 1'b1;
    repeat (8) @(posedge sys_clk);
    `CHK(pacerOut, 1'b1)
    extPacer <= 1'b0;
    repeat (1300) @(posedge sys_clk);
    `CHK(pacerOut, 1'b0)
    `CHK(starts[1] - starts[0], 400)
    apb(1, `REG_CTRL, 32'h5);
    // every trigger mode arms, then starts on its event
    for (int m = 0; m < 4; m++) begin
      extStart <= m[0];
      repeat (8) @(posedge sys_clk);
      apb(1, `REG_CTRL, 32'h23 | (m << 6));
      apb(0, `REG_STAT, 0); `CHK(rd[1:0], 2'b10)
      extStart <= ~m[0];
      repeat (10) @(posedge sys_clk);
      apb(0, `REG_STAT, 0); `CHK(rd[1:0], 2'b01)
      apb(1, `REG_CTRL, 32'h5);
    end
    // host stalls: fifo fills and the scan stops with overrun
    repeat (80) @(posedge sys_clk);
    drainEn <= 1'b0;
    apb(1, `REG_PACER, 0);
    apb(1, `REG_CTRL, 32'h0B);
    waitStat(`STAT_OVR, 1'b1);
    `CHK(rd[`STAT_RUN], 1'b0)
    `CHK(rd[10:8], 3'h4)
    `CHK(xferBlock, 1'b1)
    `CHK(actLed, 1'b0)
    got.delete();
    actSeen <= 1'b0;
    drainEn <= 1'b1;
    repeat (20) @(posedge sys_clk);
    `CHK(got.size(), 4)
    `CHK(actSeen, 1'b1)
    apb(1, `REG_STAT, 32'h4);
    apb(0, `REG_STAT, 0); `CHK(rd[2], 1'b0)
    repeat (40) @(posedge sys_clk);
    `CHK(actLed, 1'b0)
    // status indicator over configure, loss and reconnection
    for (int i = 0; i < 6; i++) begin
      {usbAtt, usbCfg} <= stTab[i];
      repeat (4) @(posedge sys_clk);
      `CHK(statusLed, ledExp[i])
    end
    testDone();
  end
endmodule
`default_nettype wire
